//--- t1_pulse_density_enforcer_bench.sv
// Purpose : Self-checking bench of the transmit density enforcer.
// Assumes : APB master with one outstanding transfer.
// Notes   : 200 ones refill the history between stream tests.
`timescale 1ns/1ps
`default_nettype none
`include "tpde_regs.svh"

// ============================================================
// Bench
// ============================================================
module t1_pulse_density_enforcer_bench;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        err;
  } tpde_row_t;
  localparam logic [11:0] ENF = `TPDE_ADDR_ENFORCER;
  localparam logic [11:0] GLB = `TPDE_ADDR_GLOBAL_CFG;
  tpde_row_t rows [6] = '{'{ENF, 32'hc3, 32'hc3, 1'b0}, '{ENF, 32'hffffffff, 32'hc3, 1'b0},
    '{ENF, 32'h3c, 32'h0, 1'b0}, '{12'h004, 32'hff, 32'h0, 1'b1},
    '{GLB, 32'h0, 32'h0, 1'b0}, '{12'hffc, 32'h1, 32'h0, 1'b1}};
  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, o0;
  logic        er_v, in_bit, in_valid, out_bit, out_valid, irq_n;
  logic        src_start, src_pat, src_busy;
  logic [7:0]  src_len;
  logic [31:0] ones = 32'h0;
  int          err_total = 0;
  int          tests_run = 0;

  tpde_enforcer u_dut (.SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PCM_IN_BIT(in_bit), .PCM_IN_VALID(in_valid),
    .PCM_OUT_BIT(out_bit), .PCM_OUT_VALID(out_valid), .IRQ_OUT_N(irq_n));
  tpde_pcm_src u_src (.clk(sys_clk), .rst(reset), .start(src_start), .pat(src_pat),
    .len(src_len), .pcm_bit(in_bit), .pcm_valid(in_valid), .busy(src_busy));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Ones seen on the line
  always @(posedge sys_clk) begin
    if (out_valid === 1'b1 && out_bit === 1'b1) ones <= ones + 32'h1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; waits on PREADY, never on a cycle count
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) err_total++;
    rd_v = prdata;
    er_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic b, input logic [7:0] n);
    int k;
    @(posedge sys_clk);
    src_start <= 1'b1;
    src_pat   <= b;
    src_len   <= n;
    @(posedge sys_clk);
    src_start <= 1'b0;
    k = 0;
    while (src_busy === 1'b1 && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 300) err_total++;
    repeat (3) @(posedge sys_clk);
  endtask

  // Longest path is well under 8000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end

  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {src_start, src_pat, src_len} = 10'h0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, rows[i].addr, rows[i].wdata);
      check("wr_err", {31'h0, er_v}, {31'h0, rows[i].err});
      apb(1'b0, rows[i].addr, 32'h0);
      check("rd_data", rd_v, rows[i].rdata);
      check("rd_err", {31'h0, er_v}, {31'h0, rows[i].err});
    end
    $display("register table done");
    // Fill off, zero-run and violation interrupts on
    apb(1'b1, ENF, 32'h03);
    send(1'b0, 8'd16);
    check("irq_onset", {31'h0, irq_n}, 32'h0);
    apb(1'b0, ENF, 32'h0);
    check("flags", rd_v, 32'h1f);
    // Pin trails the cleared flags by one cycle
    @(posedge sys_clk);
    check("irq_read", {31'h0, irq_n}, 32'h1);
    apb(1'b0, ENF, 32'h0);
    check("live_only", rd_v, 32'h13);
    send(1'b1, 8'd1);
    check("irq_end", {31'h0, irq_n}, 32'h0);
    check("ones_pass", ones, 32'h1);
    apb(1'b0, ENF, 32'h0);
    check("end_flags", rd_v, 32'h07);
    $display("pass-through test done");
    // Enables off: flags still latch, no interrupt
    send(1'b1, 8'd200);
    apb(1'b1, ENF, 32'h00);
    send(1'b0, 8'd16);
    check("irq_quiet", {31'h0, irq_n}, 32'h1);
    apb(1'b0, ENF, 32'h0);
    check("masked_flags", rd_v, 32'h1c);
    $display("masked test done");
    // Fill on with its interrupt; one stuffed bit expected in 20
    send(1'b1, 8'd200);
    apb(1'b1, ENF, 32'hc3);
    o0 = ones;
    send(1'b0, 8'd20);
    check("stuffed", ones - o0, 32'h1);
    check("irq_fill", {31'h0, irq_n}, 32'h0);
    apb(1'b0, ENF, 32'h0);
    check("fill_flags", rd_v, 32'he3);
    @(posedge sys_clk);
    check("irq_fill_rd", {31'h0, irq_n}, 32'h1);
    apb(1'b1, ENF, 32'h40);
    send(1'b0, 8'd20);
    check("irq_fill_off", {31'h0, irq_n}, 32'h1);
    apb(1'b0, ENF, 32'h0);
    check("fill_only", rd_v, 32'h60);
    $display("fill test done");
    // E1 holds the register at reset
    apb(1'b1, GLB, 32'h1);
    apb(1'b0, ENF, 32'h0);
    check("e1_read", rd_v, 32'h0);
    apb(1'b1, ENF, 32'hff);
    apb(1'b0, ENF, 32'h0);
    check("e1_write", rd_v, 32'h0);
    apb(1'b1, GLB, 32'h0);
    apb(1'b0, ENF, 32'h0);
    check("t1_back", rd_v, 32'h0);
    $display("line standard test done");
    // Reset in mid-run
    apb(1'b1, ENF, 32'h83);
    send(1'b0, 8'd16);
    check("irq_pre_rst", {31'h0, irq_n}, 32'h0);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, ENF, 32'h0);
    check("reset_val", rd_v, 32'h0);
    check("reset_irq", {31'h0, irq_n}, 32'h1);
    $display("reset test done");
    print_verdict();
  end
endmodule
`default_nettype wire

//--- tpde_enforcer.sv
// Purpose : Transmit T1 pulse density enforcer with APB register access.
// Assumes : PCM bits arrive from same-clock framer logic with a valid strobe;
//           one bit per valid cycle.
// Notes   : Output stream is one cycle behind the input stream.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tpde_regs.svh"

module tpde_enforcer #(
  parameter int MAX_N = `TPDE_MAX_N,
  parameter int ZRUN  = `TPDE_ZERO_RUN
) (
  input  wire logic                      SYS_CLK,
  input  wire logic                      RESET,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [`TPDE_ADDR_W-1:0]   PADDR,
  input  wire logic [31:0]               PWDATA,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  input  wire logic                      PCM_IN_BIT,
  input  wire logic                      PCM_IN_VALID,
  output logic                           PCM_OUT_BIT,
  output logic                           PCM_OUT_VALID,
  output logic                           IRQ_OUT_N
);

  // ============================================================
  // Declarations
  // ============================================================
  localparam int HLEN = 8 * (MAX_N + 1);

  tpde_pkg::tpde_apb_st_t apb_st_q;

  logic                          line_standard_select_q;
  logic                          fill_event_irq_enable_q;
  logic                          fill_enable_q;
  logic                          fill_event_flag_q;
  logic                          density_violation_now_q;
  logic                          zero_run_flag_q;
  logic                          violation_change_flag_q;
  logic                          zero_run_irq_enable_q;
  logic                          violation_irq_enable_q;

  logic [HLEN-1:0]               hist_q;
  logic [`TPDE_ZRUN_W-1:0]       zrun_q;
  logic [`TPDE_ZRUN_W-1:0]       zrun_d;
  logic [MAX_N-1:0]              win_fail0;
  logic [MAX_N-1:0]              win_fail;

  logic                          out_bit_d;
  logic                          stuff_now;
  logic                          viol_d;
  logic                          viol_live_d;
  logic                          zrun_hit;
  logic                          vchg_set;
  logic                          zrun_set;
  logic                          fill_set;

  logic                          apb_access;
  logic                          hit_enf;
  logic                          hit_cfg;
  logic                          wr_enf;
  logic                          wr_cfg;
  logic                          rd_enf;
  logic                          held;
  logic [7:0]                    enf_view;
  logic                          irq_any;

  // ============================================================
  // Sliding windows of the density rule
  // ============================================================
  // One counter per N; each drops the bit that leaves its window and adds
  // the bit actually sent, so stuffing decisions see the outgoing stream.
  genvar gi;
  generate
    for (gi = 1; gi <= MAX_N; gi++) begin : g_win
      tpde_window #(
        .LEN   (8 * (gi + 1)),
        .NMIN  (gi),
        .CNT_W (`TPDE_CNT_W)
      ) u_win (
        .clk          (SYS_CLK),
        .rst          (RESET),
        .shift        (PCM_IN_VALID),
        .leave_bit    (hist_q[8 * (gi + 1) - 1]),
        .new_bit      (out_bit_d),
        .fail_if_zero (win_fail0[gi-1]),
        .fail_now     (win_fail[gi-1])
      );
    end
  endgenerate

  // ============================================================
  // Stuffing decision and violation detection
  // ============================================================
  // A zero is replaced only when it would itself cause a violation; a one
  // can never make a window poorer, so forcing one always cures it.
  always_comb begin
    stuff_now = fill_enable_q && !PCM_IN_BIT &&
                ((|win_fail0) || (zrun_q >= `TPDE_ZRUN_W'(ZRUN - 1)));
    out_bit_d = PCM_IN_BIT | stuff_now;
    zrun_d    = out_bit_d ? '0 :
                ((zrun_q == `TPDE_ZRUN_W'(ZRUN)) ? zrun_q : zrun_q + 1'b1);
    zrun_hit  = !out_bit_d && (zrun_q == `TPDE_ZRUN_W'(ZRUN - 1));
    viol_d    = (|win_fail) || (zrun_d >= `TPDE_ZRUN_W'(ZRUN));
  end

  // History of sent bits; preset to ones so start-up is not a violation
  // It keeps running in E1 mode; only the register is held there.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      hist_q <= '1;
      zrun_q <= '0;
    end else if (PCM_IN_VALID) begin
      hist_q <= {hist_q[HLEN-2:0], out_bit_d};
      zrun_q <= zrun_d;
    end
  end

  // Outgoing stream, registered
  // One cycle of latency buys a line output straight from a flop.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PCM_OUT_BIT   <= 1'b0;
      PCM_OUT_VALID <= 1'b0;
    end else begin
      PCM_OUT_BIT   <= out_bit_d;
      PCM_OUT_VALID <= PCM_IN_VALID;
    end
  end

  // ============================================================
  // Events feeding the latched flags
  // ============================================================
  // Live bit is meaningless while stuffing keeps the stream clean, so it
  // is pinned low then, from the first cycle of filling rather than from
  // the next bit, and no change events arise from it. Between bits it
  // keeps its value: the condition only moves when a bit is sent.
  always_comb begin
    if (held || fill_enable_q) begin
      viol_live_d = 1'b0;
    end else if (PCM_IN_VALID) begin
      viol_live_d = viol_d;
    end else begin
      viol_live_d = density_violation_now_q;
    end
    vchg_set    = !held && !fill_enable_q &&
                  (viol_live_d != density_violation_now_q);
    zrun_set    = !held && !fill_enable_q && PCM_IN_VALID && zrun_hit;
    fill_set    = !held && PCM_IN_VALID && stuff_now;
  end

  // Live violation bit, one bit time resolution, no latch
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      density_violation_now_q <= 1'b0;
    end else begin
      density_violation_now_q <= viol_live_d;
    end
  end

  // ============================================================
  // APB slave
  // ============================================================
  // One wait state: PREADY rises in the first access cycle's following
  // edge, which also lets read data come straight from a flop.
  always_comb begin
    apb_access = PSEL && PENABLE && (apb_st_q == tpde_pkg::TPDE_APB_WAIT);
    hit_enf    = (PADDR == `TPDE_ADDR_ENFORCER);
    hit_cfg    = (PADDR == `TPDE_ADDR_GLOBAL_CFG);
    wr_enf     = apb_access && PWRITE && hit_enf;
    wr_cfg     = apb_access && PWRITE && hit_cfg;
    rd_enf     = apb_access && !PWRITE && hit_enf;
    held       = line_standard_select_q;
  end

  // Answer sequencing
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      apb_st_q <= tpde_pkg::TPDE_APB_WAIT;
      PREADY   <= 1'b0;
      PSLVERR  <= 1'b0;
    end else begin
      unique case (apb_st_q)
        tpde_pkg::TPDE_APB_WAIT: begin
          PREADY  <= apb_access;
          PSLVERR <= apb_access && !hit_enf && !hit_cfg;
          if (apb_access) begin
            apb_st_q <= tpde_pkg::TPDE_APB_DONE;
          end
        end
        tpde_pkg::TPDE_APB_DONE: begin
          PREADY   <= 1'b0;
          PSLVERR  <= 1'b0;
          apb_st_q <= tpde_pkg::TPDE_APB_WAIT;
        end
      endcase
    end
  end

  // Snapshot of the enforcer register as software sees it
  always_comb begin
    enf_view                         = `TPDE_RST_ENFORCER;
    enf_view[`TPDE_B_FILL_IRQ_EN]    = fill_event_irq_enable_q;
    enf_view[`TPDE_B_FILL_EN]        = fill_enable_q;
    enf_view[`TPDE_B_FILL_FLAG]      = fill_event_flag_q;
    enf_view[`TPDE_B_VIOL_NOW]       = density_violation_now_q;
    enf_view[`TPDE_B_ZRUN_FLAG]      = zero_run_flag_q;
    enf_view[`TPDE_B_VCHG_FLAG]      = violation_change_flag_q;
    enf_view[`TPDE_B_ZRUN_IRQ_EN]    = zero_run_irq_enable_q;
    enf_view[`TPDE_B_VIOL_IRQ_EN]    = violation_irq_enable_q;
  end

  // Read data, captured in the access cycle; zero for unmapped addresses
  // Zero between answers keeps stale register contents off the bus.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (apb_access && !PWRITE) begin
      if (hit_enf) begin
        PRDATA <= {24'h00_0000, enf_view};
      end else if (hit_cfg) begin
        PRDATA <= {31'h0000_0000, line_standard_select_q};
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end else begin
      PRDATA <= 32'h0000_0000;
    end
  end

  // ============================================================
  // Global configuration
  // ============================================================
  // Line standard select; one means E1 and holds the enforcer register at reset
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      line_standard_select_q <= `TPDE_RST_LINE_STD;
    end else if (wr_cfg) begin
      line_standard_select_q <= PWDATA[`TPDE_B_LINE_STD];
    end
  end

  // ============================================================
  // Enforcer register: enables
  // ============================================================
  // E1 mode keeps every field at reset and ignores writes to it.
  // Writes made while held are lost, not deferred until T1 returns.
  always_ff @(posedge SYS_CLK) begin
    if (RESET || held) begin
      fill_event_irq_enable_q <= 1'b0;
      fill_enable_q           <= 1'b0;
      zero_run_irq_enable_q   <= 1'b0;
      violation_irq_enable_q  <= 1'b0;
    end else if (wr_enf) begin
      fill_event_irq_enable_q <= PWDATA[`TPDE_B_FILL_IRQ_EN];
      fill_enable_q           <= PWDATA[`TPDE_B_FILL_EN];
      zero_run_irq_enable_q   <= PWDATA[`TPDE_B_ZRUN_IRQ_EN];
      violation_irq_enable_q  <= PWDATA[`TPDE_B_VIOL_IRQ_EN];
    end
  end

  // ============================================================
  // Enforcer register: latched flags
  // ============================================================
  // Cleared by a completed read or by writing one; a new event in the same
  // cycle wins, so nothing is lost between the read and the clear.
  // Writing one clears too, so a polling driver need not read to acknowledge.
  always_ff @(posedge SYS_CLK) begin
    if (RESET || held) begin
      fill_event_flag_q <= 1'b0;
    end else if (fill_set) begin
      fill_event_flag_q <= 1'b1;
    end else if (rd_enf || (wr_enf && PWDATA[`TPDE_B_FILL_FLAG])) begin
      fill_event_flag_q <= 1'b0;
    end
  end

  // Change and zero-run flags are held low whenever filling is on
  always_ff @(posedge SYS_CLK) begin
    if (RESET || held || fill_enable_q) begin
      violation_change_flag_q <= 1'b0;
    end else if (vchg_set) begin
      violation_change_flag_q <= 1'b1;
    end else if (rd_enf || (wr_enf && PWDATA[`TPDE_B_VCHG_FLAG])) begin
      violation_change_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET || held || fill_enable_q) begin
      zero_run_flag_q <= 1'b0;
    end else if (zrun_set) begin
      zero_run_flag_q <= 1'b1;
    end else if (rd_enf || (wr_enf && PWDATA[`TPDE_B_ZRUN_FLAG])) begin
      zero_run_flag_q <= 1'b0;
    end
  end

  // ============================================================
  // Interrupt request
  // ============================================================
  // Level output: follows the enabled flags, the change flag only while the fill interrupt is disabled, so clearing them drops the request.
  // Limitation: the pin trails the flags by one cycle, so right after a
  // clearing read it still shows the old request for one more cycle.
  always_comb begin
    irq_any = (fill_event_flag_q && fill_event_irq_enable_q) ||
              (zero_run_flag_q && zero_run_irq_enable_q) ||
              (violation_change_flag_q && violation_irq_enable_q &&
               !fill_event_irq_enable_q);
  end

  // Active low, registered so the pin never glitches
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      IRQ_OUT_N <= 1'b1;
    end else begin
      IRQ_OUT_N <= !irq_any;
    end
  end

endmodule

`default_nettype wire

//--- tpde_enforcer_checker.sv
// Purpose : Port-level checks of the transmit density enforcer.
// Assumes : One clock, synchronous active-high reset.
// Notes   : Mode bits are shadowed from completed APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "tpde_regs.svh"

// ============================================================
// Checker
// ============================================================
module tpde_enforcer_checker #(
  parameter int MAX_N = `TPDE_MAX_N,
  parameter int ZRUN  = `TPDE_ZERO_RUN
) (
  input wire logic                    SYS_CLK,
  input wire logic                    RESET,
  input wire logic                    PSEL,
  input wire logic                    PENABLE,
  input wire logic                    PWRITE,
  input wire logic [`TPDE_ADDR_W-1:0] PADDR,
  input wire logic [31:0]             PWDATA,
  input wire logic [31:0]             PRDATA,
  input wire logic                    PREADY,
  input wire logic                    PSLVERR,
  input wire logic                    PCM_IN_BIT,
  input wire logic                    PCM_IN_VALID,
  input wire logic                    PCM_OUT_BIT,
  input wire logic                    PCM_OUT_VALID,
  input wire logic                    IRQ_OUT_N
);
  logic       e1_q;
  logic [7:0] en_q;
  logic [7:0] zcnt_q;
  logic       wr_done;
  logic       rd_enf;
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_enf  = PREADY && !PWRITE && (PADDR == `TPDE_ADDR_ENFORCER);
  // Shadow of line standard and enables; lags the device by one edge
  always_ff @(posedge SYS_CLK) begin
    if (RESET || (wr_done && PADDR == `TPDE_ADDR_GLOBAL_CFG && PWDATA[0])) begin
      en_q <= 8'h00;
    end else if (wr_done && PADDR == `TPDE_ADDR_ENFORCER && !e1_q) begin
      en_q <= PWDATA[7:0] & 8'hc3;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      e1_q <= 1'b0;
    end else if (wr_done && PADDR == `TPDE_ADDR_GLOBAL_CFG) begin
      e1_q <= PWDATA[0];
    end
  end
  // Zeros in a row on the line while filling; restarts when fill is off
  always_ff @(posedge SYS_CLK) begin
    if (RESET || !en_q[6]) begin
      zcnt_q <= 8'h00;
    end else if (PCM_OUT_VALID) begin
      zcnt_q <= PCM_OUT_BIT ? 8'h00 : zcnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  AST_OUT_VALID: assert property (!$past(RESET) |-> PCM_OUT_VALID == $past(PCM_IN_VALID))
    else $error("output strobe not one cycle behind input");
  AST_ONES_KEPT: assert property (PCM_OUT_VALID && $past(PCM_IN_BIT) |-> PCM_OUT_BIT)
    else $error("a one was dropped");
  AST_PASS_THRU: assert property (PCM_OUT_VALID && !en_q[6] |-> PCM_OUT_BIT == $past(PCM_IN_BIT))
    else $error("data altered with fill off");
  AST_ZERO_LIMIT: assert property (zcnt_q < ZRUN)
    else $error("too many zeros sent with fill on");
  AST_PREADY_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("answer late");
  AST_PREADY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  AST_SLVERR: assert property (PREADY |-> PSLVERR == !(PADDR == `TPDE_ADDR_ENFORCER
                               || PADDR == `TPDE_ADDR_GLOBAL_CFG))
    else $error("error response wrong");
  AST_E1_HELD: assert property (rd_enf && e1_q |-> PRDATA == 32'h0)
    else $error("register not held in E1");
  AST_FILL_QUIET: assert property (rd_enf && en_q[6] |-> PRDATA[4:2] == 3'h0)
    else $error("violation bits set while filling");
  AST_IRQ_CAUSE: assert property (!IRQ_OUT_N |-> en_q[7] || en_q[1] || en_q[0])
    else $error("interrupt with no enable");
  AST_READ_CLEARS: assert property (rd_enf && !PCM_OUT_VALID |=> IRQ_OUT_N)
    else $error("interrupt not cleared by read");
endmodule

bind tpde_enforcer tpde_enforcer_checker #(.MAX_N(MAX_N), .ZRUN(ZRUN)) u_chk (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PCM_IN_BIT(PCM_IN_BIT),
  .PCM_IN_VALID(PCM_IN_VALID), .PCM_OUT_BIT(PCM_OUT_BIT),
  .PCM_OUT_VALID(PCM_OUT_VALID), .IRQ_OUT_N(IRQ_OUT_N));
`default_nettype wire

//--- tpde_pcm_src.sv
// Purpose : Framer-side model sending bursts of one bit value.
// Assumes : Same clock as the enforcer, no back-pressure.
// Notes   : Idle line shows the inverse of the last burst value.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Burst source
// ============================================================
module tpde_pcm_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       pat,
  input  wire logic [7:0] len,
  output logic            pcm_bit,
  output logic            pcm_valid,
  output logic            busy
);
  logic [7:0] left_q;
  logic       bit_q;
  // One bit each cycle, back to back, for len cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      left_q <= 8'h00;
      bit_q  <= 1'b1;
    end else if (start) begin
      left_q <= len;
      bit_q  <= pat;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  assign pcm_valid = (left_q != 8'h00);
  // Stale data would hide a sampling slip, so the idle line flips
  assign pcm_bit   = pcm_valid ? bit_q : !bit_q;
  assign busy      = start || pcm_valid;
endmodule
`default_nettype wire

//--- tpde_pkg.sv
// Purpose : Shared types of the transmit pulse density enforcer.
// Assumes : Constants come from tpde_regs.svh.
// Notes   : Types only.
package tpde_pkg;

  // APB answer sequencing
  typedef enum logic [0:0] {
    TPDE_APB_WAIT = 1'b0,
    TPDE_APB_DONE = 1'b1
  } tpde_apb_st_t;

endpackage

//--- tpde_regs.svh
// Purpose : Register map, field positions and stream constants for the
//           transmit pulse density enforcer.
// Assumes : 32-bit APB data, byte addresses on PADDR.
// Notes   : Definitions only; included by the package users by bare name.
`ifndef TPDE_REGS_SVH
`define TPDE_REGS_SVH

// ============================================================
// Addresses
// ============================================================
// Register index of the enforcer control/status register
`define TPDE_IDX_ENFORCER     12'h069
// Byte address is four times the index
`define TPDE_ADDR_ENFORCER    12'h1a4
// Global configuration register holding the line standard select
`define TPDE_ADDR_GLOBAL_CFG  12'h000
`define TPDE_ADDR_W           12

// ============================================================
// Field positions of the enforcer register
// ============================================================
`define TPDE_B_FILL_IRQ_EN    7
`define TPDE_B_FILL_EN        6
`define TPDE_B_FILL_FLAG      5
`define TPDE_B_VIOL_NOW       4
`define TPDE_B_ZRUN_FLAG      3
`define TPDE_B_VCHG_FLAG      2
`define TPDE_B_ZRUN_IRQ_EN    1
`define TPDE_B_VIOL_IRQ_EN    0
// Field of the global configuration register
`define TPDE_B_LINE_STD       0

// ============================================================
// Reset values and density figures
// ============================================================
`define TPDE_RST_ENFORCER     8'h00
`define TPDE_RST_LINE_STD     1'b0
// Largest N of the N-ones-in-8(N+1)-bits rule
`define TPDE_MAX_N            23
// Longest window, 8 * (MAX_N + 1) bits
`define TPDE_HIST_LEN         192
// Zeros in a row that make a zero-run event
`define TPDE_ZERO_RUN         16
`define TPDE_ZRUN_W           5
`define TPDE_CNT_W            8

`endif

//--- tpde_window.sv
// Purpose : Ones counter over one sliding window of the density rule.
// Assumes : Caller supplies the bit leaving the window from its history.
// Notes   : Count starts full, matching a history preset to ones.
`timescale 1ns/1ps
`default_nettype none
`include "tpde_regs.svh"

module tpde_window #(
  parameter int LEN   = 16,
  parameter int NMIN  = 1,
  parameter int CNT_W = `TPDE_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             shift,
  input  wire logic             leave_bit,
  input  wire logic             new_bit,
  output logic                  fail_if_zero,
  output logic                  fail_now
);

  localparam logic [CNT_W-1:0] FULL = CNT_W'(LEN);
  localparam logic [CNT_W-1:0] NEED = CNT_W'(NMIN);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] base;
  logic [CNT_W-1:0] cnt_d;

  // Count after the leaving bit is dropped, before the new bit lands
  always_comb begin
    base         = cnt_q - CNT_W'(leave_bit);
    cnt_d        = base + CNT_W'(new_bit);
    fail_if_zero = (base < NEED);
    fail_now     = (cnt_d < NEED);
  end

  // Window count update, once per stream bit
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= FULL;
    end else if (shift) begin
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire
